/* hw/dbsc_pkg.sv */
// Shared constants and carrier types for the display bias sequencing register bank.
package dbsc_pkg;

  // Register offsets; the two delay registers have offsets of our choosing.
  localparam logic [7:0] DBSC_OFS_LEVEL = 8'h0c;
  localparam logic [7:0] DBSC_OFS_POS = 8'h0d;
  localparam logic [7:0] DBSC_OFS_NEG = 8'h0e;
  localparam logic [7:0] DBSC_OFS_REF = 8'h0f;
  localparam logic [7:0] DBSC_OFS_NEG_DLY = 8'h10;
  localparam logic [7:0] DBSC_OFS_REF_DLY = 8'h11;
  localparam logic [7:0] DBSC_OFS_FLAG = 8'h13;
  localparam logic [7:0] DBSC_OFS_SRST = 8'h14;
  localparam logic [7:0] DBSC_OFS_REV = 8'h16;

  // Reset values (plain defaults) and writable masks.
  localparam logic [7:0] DBSC_RST_LEVEL = 8'h00;
  localparam logic [7:0] DBSC_RST_TARGET = 8'h00;
  localparam logic [7:0] DBSC_RST_DLY = 8'h00;
  localparam logic [7:0] DBSC_RST_FLAG = 8'h00;
  localparam logic [7:0] DBSC_MASK_TARGET = 8'h3f;
  localparam logic [7:0] DBSC_MASK_FLAG = 8'h1f;
  localparam logic [7:0] DBSC_SRST_KEY = 8'hff;

  // Field positions.
  localparam int DBSC_CTRL_LSB = 6;
  localparam int DBSC_BOOST_MSB = 5;
  localparam int DBSC_DLY_UP_LSB = 4;
  localparam int DBSC_FLAG_POL_BIT = 4;
  localparam int DBSC_PG_SRC_LSB = 2;

  // Indication source and power-good source codes.
  localparam logic [1:0] DBSC_IND_OFF = 2'h0;
  localparam logic [1:0] DBSC_IND_PG = 2'h1;
  localparam logic [1:0] DBSC_IND_BL = 2'h2;
  localparam logic [1:0] DBSC_IND_FAULT = 2'h3;
  localparam logic [1:0] DBSC_PG_LAST = 2'h0;
  localparam logic [1:0] DBSC_PG_POS = 2'h1;
  localparam logic [1:0] DBSC_PG_NEG = 2'h2;
  localparam logic [1:0] DBSC_PG_REF = 2'h3;

  // Timing: one millisecond tick from the 100 MHz clock.
  localparam int DBSC_CLK_MHZ = 100;
  localparam int DBSC_TICK_US = 1000;
  localparam int DBSC_TICK_CYCLES = DBSC_TICK_US * DBSC_CLK_MHZ;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dbsc_req_type;

  typedef struct packed {
    logic [1:0] control_supply_level;
    logic [5:0] bias_boost_level;
    logic [5:0] positive_output_target;
    logic [5:0] negative_output_target;
    logic [5:0] reference_output_target;
  } dbsc_levels_type;

endpackage : dbsc_pkg

/* hw/dbsc_ms_tick.sv */
// Millisecond tick divider: one-cycle enable pulse per period.
`timescale 1ns/10ps
`default_nettype none
module dbsc_ms_tick
  import dbsc_pkg::*;
#(
  parameter int CYCLES = DBSC_TICK_CYCLES
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Tick out
  output logic o_tick
);
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } dbsc_tick_st_type;

  dbsc_tick_st_type st_q, st_d;

  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (st_q.cnt == 32'(CYCLES - 1)) begin
      st_d.cnt = 32'h0;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + 32'h1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_tick = st_q.tick;
endmodule // dbsc_ms_tick
`default_nettype wire

/* hw/dbsc_seq_delay.sv */
// One output's sequencing delay: counts ms ticks after a trigger.
`timescale 1ns/10ps
`default_nettype none
module dbsc_seq_delay
  import dbsc_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_tick,
  input wire logic i_req_on,
  input wire logic [3:0] i_up_ms,
  input wire logic [3:0] i_down_ms,
  // Status
  output logic o_on
);
  typedef struct packed {
    logic on;
    logic [3:0] cnt;
  } dbsc_dly_st_type;

  dbsc_dly_st_type st_q, st_d;
  logic [3:0] target;

  // Counter restarts whenever the request flips, so a late flip cannot
  // inherit a half-finished count from the opposite direction.
  always_comb begin
    st_d = st_q;
    target = i_req_on ? i_up_ms : i_down_ms;
    if (i_req_on == st_q.on) begin
      st_d.cnt = 4'h0;
    end else if (st_q.cnt >= target) begin // R15
      st_d.on = i_req_on;
      st_d.cnt = 4'h0;
    end else if (i_tick) begin
      st_d.cnt = st_q.cnt + 4'h1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_on = st_q.on;

  property p_zero_delay_next;
    @(posedge i_core_clk) disable iff (i_rst)
      (i_req_on && !st_q.on && i_up_ms == 4'h0) |=> st_q.on;
  endproperty
  a_zero_delay_next: assert property (p_zero_delay_next) // R15
    else $error("Zero start-up delay did not switch on next cycle.");
endmodule // dbsc_seq_delay
`default_nettype wire

/* hw/dbsc_regs.sv */
// Register bank with sequencing and indication-pin logic.
// What this block does
// R01: Control supply level field, two bits.
// R02: Bias boost level field, six bits.
// R03: Negative output start-up delay in ms.
// R04: Negative output shutdown delay in ms.
// R05: Reference output start-up delay in ms.
// R06: Reference output shutdown delay in ms.
// R07: Polarity bit sets flag pin level.
// R08: Source field selects flag pin report.
// R09: Backlight-on shown when source is 10.
// R10: Power-good source picks which output.
// R11: Writing FFh resets all registers.
// R12: Revision register fields traceability, OTP, device.
// R13: Backlight waits until enabled bias settled.
// R14: Unused bits read zero, ignore writes.
// R15: Delays counted by millisecond tick counter.
`timescale 1ns/10ps
`default_nettype none
module dbsc_regs
  import dbsc_pkg::*;
#(
  parameter int TICK_CYCLES = DBSC_TICK_CYCLES,
  parameter logic [1:0] DIE_TRACE = 2'h0,  // Arbitrary value.
  parameter logic [2:0] OTP_REV = 3'h0,    // Arbitrary value.
  parameter logic [2:0] DEV_REV = 3'h1     // Arbitrary value.
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Register access from the serial-interface front end
  input wire dbsc_req_type i_req,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  // Sequencing requests and analog status
  input wire logic i_bias_enable_pin,
  input wire logic i_neg_req,
  input wire logic i_ref_req,
  input wire logic i_pos_settled,
  input wire logic i_neg_settled,
  input wire logic i_ref_settled,
  input wire logic i_pos_en,
  input wire logic i_backlight_req,
  input wire logic i_fault,
  // Analog controls
  output dbsc_levels_type o_levels,
  output logic o_neg_on,
  output logic o_ref_on,
  output logic o_backlight_on,
  // Indication pin
  output logic o_flag
);
  typedef struct packed {
    logic [7:0] level;
    logic [7:0] pos;
    logic [7:0] neg;
    logic [7:0] ref_lvl;
    logic [7:0] neg_dly;
    logic [7:0] ref_dly;
    logic [7:0] flag_cfg;
    logic [7:0] rdata;
    logic rvalid;
    logic bl_on;
    logic flag;
  } dbsc_st_type;

  dbsc_st_type st_q, st_d;
  logic tick;
  logic neg_on;
  logic ref_on;
  logic neg_ok;
  logic ref_ok;
  logic bias_ok;
  logic pg;
  logic ind;
  logic soft_rst;
  logic cfg_held;

  dbsc_ms_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .o_tick(tick)
  );

  dbsc_seq_delay u_neg (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst | soft_rst),
    .i_tick(tick),
    .i_req_on(i_neg_req & i_bias_enable_pin),
    .i_up_ms(st_q.neg_dly[7:DBSC_DLY_UP_LSB]), // R03
    .i_down_ms(st_q.neg_dly[DBSC_DLY_UP_LSB-1:0]), // R04
    .o_on(neg_on)
  );

  dbsc_seq_delay u_ref (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst | soft_rst),
    .i_tick(tick),
    .i_req_on(i_ref_req & i_bias_enable_pin),
    .i_up_ms(st_q.ref_dly[7:DBSC_DLY_UP_LSB]), // R05
    .i_down_ms(st_q.ref_dly[DBSC_DLY_UP_LSB-1:0]), // R06
    .o_on(ref_on)
  );

  assign soft_rst = i_req.wr && i_req.addr == DBSC_OFS_SRST &&
    i_req.wdata == DBSC_SRST_KEY; // R11

  // Flag config steady over an edge, so the pin simply follows its source.
  assign cfg_held = !soft_rst &&
    !(i_req.wr && i_req.addr == DBSC_OFS_FLAG);

  // Settled means switched on and at target; disabled outputs do not block.
  assign neg_ok = neg_on & i_neg_settled;
  assign ref_ok = ref_on & i_ref_settled;
  assign bias_ok = (!i_pos_en || i_pos_settled) &&
    (!(i_neg_req & i_bias_enable_pin) || neg_ok) &&
    (!(i_ref_req & i_bias_enable_pin) || ref_ok); // R13

  always_comb begin
    pg = 1'b0;
    case (st_q.flag_cfg[DBSC_PG_SRC_LSB+1:DBSC_PG_SRC_LSB]) // R10
      DBSC_PG_LAST: pg = i_bias_enable_pin && bias_ok;
      DBSC_PG_POS: pg = i_pos_en && i_pos_settled;
      DBSC_PG_NEG: pg = neg_ok;
      DBSC_PG_REF: pg = ref_ok;
      default: pg = 1'b0;
    endcase
  end

  always_comb begin
    ind = 1'b0;
    case (st_q.flag_cfg[1:0]) // R08
      DBSC_IND_OFF: ind = 1'b0;
      DBSC_IND_PG: ind = pg;
      DBSC_IND_BL: ind = st_q.bl_on; // R09
      DBSC_IND_FAULT: ind = i_fault;
      default: ind = 1'b0;
    endcase
  end

  always_comb begin
    st_d = st_q;
    st_d.rvalid = i_req.rd;
    st_d.bl_on = i_backlight_req && bias_ok; // R13
    st_d.flag = ind ~^ st_q.flag_cfg[DBSC_FLAG_POL_BIT]; // R07
    if (i_req.rd) begin
      case (i_req.addr)
        DBSC_OFS_LEVEL: st_d.rdata = st_q.level;
        DBSC_OFS_POS: st_d.rdata = st_q.pos;
        DBSC_OFS_NEG: st_d.rdata = st_q.neg;
        DBSC_OFS_REF: st_d.rdata = st_q.ref_lvl;
        DBSC_OFS_NEG_DLY: st_d.rdata = st_q.neg_dly;
        DBSC_OFS_REF_DLY: st_d.rdata = st_q.ref_dly;
        DBSC_OFS_FLAG: st_d.rdata = st_q.flag_cfg;
        DBSC_OFS_REV: st_d.rdata = {DIE_TRACE, OTP_REV, DEV_REV}; // R12
        default: st_d.rdata = 8'h00;
      endcase
    end
    if (i_req.wr) begin
      case (i_req.addr)
        DBSC_OFS_LEVEL: st_d.level = i_req.wdata; // R01 R02
        DBSC_OFS_POS: st_d.pos = i_req.wdata & DBSC_MASK_TARGET; // R14
        DBSC_OFS_NEG: st_d.neg = i_req.wdata & DBSC_MASK_TARGET; // R14
        DBSC_OFS_REF: st_d.ref_lvl = i_req.wdata & DBSC_MASK_TARGET; // R14
        DBSC_OFS_NEG_DLY: st_d.neg_dly = i_req.wdata;
        DBSC_OFS_REF_DLY: st_d.ref_dly = i_req.wdata;
        DBSC_OFS_FLAG: st_d.flag_cfg = i_req.wdata & DBSC_MASK_FLAG; // R14
        default: st_d.level = st_q.level;
      endcase
    end
    if (soft_rst) begin // R11
      st_d.level = DBSC_RST_LEVEL;
      st_d.pos = DBSC_RST_TARGET;
      st_d.neg = DBSC_RST_TARGET;
      st_d.ref_lvl = DBSC_RST_TARGET;
      st_d.neg_dly = DBSC_RST_DLY;
      st_d.ref_dly = DBSC_RST_DLY;
      st_d.flag_cfg = DBSC_RST_FLAG;
      st_d.bl_on = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st_q <= '0;
      st_q.level <= DBSC_RST_LEVEL;
      st_q.pos <= DBSC_RST_TARGET;
      st_q.neg <= DBSC_RST_TARGET;
      st_q.ref_lvl <= DBSC_RST_TARGET;
      st_q.neg_dly <= DBSC_RST_DLY;
      st_q.ref_dly <= DBSC_RST_DLY;
      st_q.flag_cfg <= DBSC_RST_FLAG;
      st_q.flag <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_rdata = st_q.rdata;
  assign o_rvalid = st_q.rvalid;
  assign o_levels.control_supply_level = st_q.level[7:DBSC_CTRL_LSB]; // R01
  assign o_levels.bias_boost_level = st_q.level[DBSC_BOOST_MSB:0]; // R02
  assign o_levels.positive_output_target = st_q.pos[5:0];
  assign o_levels.negative_output_target = st_q.neg[5:0];
  assign o_levels.reference_output_target = st_q.ref_lvl[5:0];
  assign o_neg_on = neg_on;
  assign o_ref_on = ref_on;
  assign o_backlight_on = st_q.bl_on;
  assign o_flag = st_q.flag;

  property p_soft_reset;
    @(posedge i_core_clk) disable iff (i_rst)
      soft_rst |=> (st_q.flag_cfg == DBSC_RST_FLAG && st_q.level ==
        DBSC_RST_LEVEL && st_q.neg_dly == DBSC_RST_DLY);
  endproperty
  a_soft_reset: assert property (p_soft_reset) // R11
    else $error("Soft reset key did not restore registers.");

  property p_bl_gate;
    @(posedge i_core_clk) disable iff (i_rst)
      !bias_ok |=> !o_backlight_on;
  endproperty
  a_bl_gate: assert property (p_bl_gate) // R13
    else $error("Backlight on before bias settled.");

  property p_bl_flag;
    @(posedge i_core_clk) disable iff (i_rst)
      (st_q.flag_cfg[1:0] == DBSC_IND_BL && !soft_rst &&
       !(i_req.wr && i_req.addr == DBSC_OFS_FLAG)) |=>
        (o_flag == (($past(o_backlight_on)) ~^ st_q.flag_cfg[4]));
  endproperty
  a_bl_flag: assert property (p_bl_flag) // R09
    else $error("Flag pin does not follow backlight state.");

  property p_flag_off;
    @(posedge i_core_clk) disable iff (i_rst)
      (st_q.flag_cfg[1:0] == DBSC_IND_OFF) |=>
        (o_flag == !$past(st_q.flag_cfg[4]));
  endproperty
  a_flag_off: assert property (p_flag_off) // R07
    else $error("Disabled flag pin not at inactive level.");

  property p_rev_read;
    @(posedge i_core_clk) disable iff (i_rst)
      (i_req.rd && i_req.addr == DBSC_OFS_REV) |=>
        (o_rvalid && o_rdata == {DIE_TRACE, OTP_REV, DEV_REV});
  endproperty
  a_rev_read: assert property (p_rev_read) // R12
    else $error("Revision read returned wrong value.");

  property p_unused_zero;
    @(posedge i_core_clk) disable iff (i_rst)
      (i_req.rd && (i_req.addr == DBSC_OFS_POS ||
       i_req.addr == DBSC_OFS_FLAG)) |=> (o_rdata[7:6] == 2'h0);
  endproperty
  a_unused_zero: assert property (p_unused_zero) // R14
    else $error("Unused bits read nonzero.");

  property p_level_out;
    @(posedge i_core_clk) disable iff (i_rst)
      (i_req.wr && i_req.addr == DBSC_OFS_LEVEL && !soft_rst) |=>
        (o_levels.control_supply_level == $past(i_req.wdata[7:6]) &&
         o_levels.bias_boost_level == $past(i_req.wdata[5:0]));
  endproperty
  a_level_out: assert property (p_level_out) // R01
    else $error("Level fields not driven from register.");

  property p_neg_delay_wait;
    @(posedge i_core_clk) disable iff (i_rst)
      ($rose(u_neg.i_req_on) && st_q.neg_dly[7:4] != 4'h0 &&
       !tick && !soft_rst) |=> !o_neg_on;
  endproperty
  a_neg_delay_wait: assert property (p_neg_delay_wait) // R03
    else $error("Negative output switched on before its delay.");

  // A lone read strobe gives a single valid pulse, never a stretched one.
  sequence s_read_alone;
    i_req.rd ##1 !i_req.rd;
  endsequence

  sequence s_valid_pulse;
    o_rvalid ##1 !o_rvalid;
  endsequence

  property p_read_pulse;
    @(posedge i_core_clk) disable iff (i_rst)
      s_read_alone |-> s_valid_pulse;
  endproperty
  a_read_pulse: assert property (p_read_pulse) // R12
    else $error("Read valid is not a single pulse.");

  property p_key_reads_zero;
    @(posedge i_core_clk) disable iff (i_rst)
      (i_req.rd && i_req.addr == DBSC_OFS_SRST) |=> (o_rdata == 8'h00);
  endproperty
  a_key_reads_zero: assert property (p_key_reads_zero) // R14
    else $error("Soft reset key register read nonzero.");

  property p_unused_ignored;
    @(posedge i_core_clk) disable iff (i_rst)
      (i_req.wr && !soft_rst) |=> (st_q.flag_cfg[7:5] == 3'h0 &&
        st_q.neg[7:6] == 2'h0 && st_q.ref_lvl[7:6] == 2'h0);
  endproperty
  a_unused_ignored: assert property (p_unused_ignored) // R14
    else $error("Unused register bits took a written value.");

  property p_fault_flag;
    @(posedge i_core_clk) disable iff (i_rst)
      (st_q.flag_cfg[1:0] == DBSC_IND_FAULT && cfg_held && i_fault) |=>
        (o_flag == st_q.flag_cfg[DBSC_FLAG_POL_BIT]);
  endproperty
  a_fault_flag: assert property (p_fault_flag) // R08
    else $error("Fault source did not drive the flag pin.");

  property p_pg_pos;
    @(posedge i_core_clk) disable iff (i_rst)
      (st_q.flag_cfg[3:0] == {DBSC_PG_POS, DBSC_IND_PG} && cfg_held &&
       i_pos_en && i_pos_settled) |=>
        (o_flag == st_q.flag_cfg[DBSC_FLAG_POL_BIT]);
  endproperty
  a_pg_pos: assert property (p_pg_pos) // R10
    else $error("Power-good from positive output not shown.");

  property p_ref_delay_wait;
    @(posedge i_core_clk) disable iff (i_rst)
      ($rose(u_ref.i_req_on) && st_q.ref_dly[7:4] != 4'h0 &&
       !tick && !soft_rst) |=> !o_ref_on;
  endproperty
  a_ref_delay_wait: assert property (p_ref_delay_wait) // R05
    else $error("Reference output switched on before its delay.");

  property p_ref_off_wait;
    @(posedge i_core_clk) disable iff (i_rst)
      ($fell(u_ref.i_req_on) && o_ref_on && st_q.ref_dly[3:0] != 4'h0 &&
       !tick && !soft_rst) |=> o_ref_on;
  endproperty
  a_ref_off_wait: assert property (p_ref_off_wait) // R06
    else $error("Reference output switched off before its delay.");

  property p_soft_stops_outputs;
    @(posedge i_core_clk) disable iff (i_rst)
      soft_rst |=> (!o_neg_on && !o_ref_on && !o_backlight_on);
  endproperty
  a_soft_stops_outputs: assert property (p_soft_stops_outputs) // R11
    else $error("Soft reset left a sequenced output on.");
endmodule // dbsc_regs
`default_nettype wire

/* test/dbsc_analog_model.sv */
// Far-side analog model: each supply settles a few cycles after turn-on.
`timescale 1ns/10ps
`default_nettype none
module dbsc_analog_model #(
  parameter int LAG = 3
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Turn-on controls
  input wire logic i_pos_en,
  input wire logic i_neg_on,
  input wire logic i_ref_on,
  // Settled status
  output logic o_pos_settled,
  output logic o_neg_settled,
  output logic o_ref_settled
);
  logic [2:0] on_now;
  int cnt_q [3];
  assign on_now = {i_ref_on, i_neg_on, i_pos_en};
  // A supply that is switched off loses regulation at once.
  always_ff @(posedge i_core_clk) begin
    for (int k = 0; k < 3; k++) begin
      if (i_rst || !on_now[k]) begin
        cnt_q[k] <= 0;
      end else if (cnt_q[k] < LAG) begin
        cnt_q[k] <= cnt_q[k] + 1;
      end
    end
  end
  assign o_pos_settled = (cnt_q[0] == LAG);
  assign o_neg_settled = (cnt_q[1] == LAG);
  assign o_ref_settled = (cnt_q[2] == LAG);
endmodule // dbsc_analog_model
`default_nettype wire

/* test/dbsc_regs_tb.sv */
// Self-checking bench for the display bias sequencing register bank.
`timescale 1ns/10ps
`default_nettype none
module dbsc_regs_tb;
  import dbsc_pkg::*;
  localparam int T = 10;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rst;
    logic [7:0] exp;
  } dbsc_row_type;
  logic clk = 1'b0;
  logic rst = 1'b1;
  dbsc_req_type req = '0;
  logic bias = 1'b0, neg_req = 1'b0, ref_req = 1'b0, pos_en = 1'b0;
  logic bl_req = 1'b0, fault = 1'b0;
  logic pos_s, neg_s, ref_s, rvalid, neg_on, ref_on, bl_on, flag;
  logic [7:0] rdata;
  dbsc_levels_type levels;
  int mismatches = 0;
  int total_checks = 0;
  dbsc_row_type rows [10] = '{
    '{8'h0c, 8'hff, 8'h00, 8'hff}, '{8'h0d, 8'hff, 8'h00, 8'h3f},
    '{8'h0e, 8'haa, 8'h00, 8'h2a}, '{8'h0f, 8'h55, 8'h00, 8'h15},
    '{8'h10, 8'ha5, 8'h00, 8'ha5}, '{8'h11, 8'h5a, 8'h00, 8'h5a},
    '{8'h13, 8'hff, 8'h00, 8'h1f}, '{8'h14, 8'h12, 8'h00, 8'h00},
    '{8'h16, 8'hff, 8'h01, 8'h01}, '{8'h20, 8'hff, 8'h00, 8'h00}};

  initial begin
    forever #5 clk = ~clk;
  end

  dbsc_regs #(.TICK_CYCLES(T)) dut_u (
    .i_core_clk(clk), .i_rst(rst), .i_req(req), .o_rdata(rdata),
    .o_rvalid(rvalid), .i_bias_enable_pin(bias), .i_neg_req(neg_req),
    .i_ref_req(ref_req), .i_pos_settled(pos_s), .i_neg_settled(neg_s),
    .i_ref_settled(ref_s), .i_pos_en(pos_en), .i_backlight_req(bl_req),
    .i_fault(fault), .o_levels(levels), .o_neg_on(neg_on),
    .o_ref_on(ref_on), .o_backlight_on(bl_on), .o_flag(flag));

  dbsc_analog_model model_u (
    .i_core_clk(clk), .i_rst(rst), .i_pos_en(pos_en), .i_neg_on(neg_on),
    .i_ref_on(ref_on), .o_pos_settled(pos_s), .o_neg_settled(neg_s),
    .o_ref_settled(ref_s));

  task automatic chk(input logic [25:0] seen, input logic [25:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = {1'b1, 1'b0, a, d};
    @(negedge clk);
    req = '0;
  endtask

  // Read data is taken only with the valid pulse, under a bounded wait.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    req = {1'b0, 1'b1, a, 8'h00};
    @(negedge clk);
    req = '0;
    d = 8'hxx;
    for (int i = 0; i < 4; i++) begin
      if (rvalid === 1'b1) begin
        d = rdata;
        break;
      end
      @(negedge clk);
    end
  endtask

  task automatic meas(input bit sel, input logic v, output int n);
    n = 0;
    while ((sel ? ref_on : neg_on) !== v && n < 400) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    mismatches++;
    print_verdict();
  end

  initial begin
    logic [7:0] d;
    int n;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    chk(flag, 1'b1);
    foreach (rows[i]) begin
      rd(rows[i].addr, d);
      chk(d, rows[i].rst);
    end
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, d);
      chk(d, rows[i].exp);
    end
    chk(levels, {2'h3, 6'h3f, 6'h3f, 6'h2a, 6'h15});
    for (int p = 0; p < 2; p++) begin
      wr(8'h13, {3'h0, p[0], 2'h0, DBSC_IND_FAULT});
      fault = 1'b1;
      repeat (2) @(negedge clk);
      chk(flag, p[0]);
      fault = 1'b0;
      repeat (2) @(negedge clk);
      chk(flag, !p[0]);
      wr(8'h13, {3'h0, p[0], 2'h0, DBSC_IND_OFF});
      fault = 1'b1;
      repeat (2) @(negedge clk);
      chk(flag, !p[0]);
      fault = 1'b0;
    end
    // Negative output waits 3 ms to start; reference waits 2 ms to stop.
    wr(8'h10, 8'h30);
    wr(8'h11, 8'h02);
    wr(8'h13, 8'h12);
    bias = 1'b1;
    bl_req = 1'b1;
    ref_req = 1'b1;
    meas(1'b1, 1'b1, n);
    chk(n <= 2, 1'b1);
    neg_req = 1'b1;
    meas(1'b0, 1'b1, n);
    chk(n >= 2 * T && n <= 3 * T + 3, 1'b1);
    chk(bl_on, 1'b0);
    repeat (6) @(negedge clk);
    chk(bl_on, 1'b1);
    chk(flag, 1'b1);
    wr(8'h13, 8'h19);
    repeat (2) @(negedge clk);
    chk(flag, 1'b1);
    wr(8'h13, 8'h15);
    repeat (2) @(negedge clk);
    chk(flag, 1'b0);
    pos_en = 1'b1;
    repeat (6) @(negedge clk);
    chk(flag, 1'b1);
    ref_req = 1'b0;
    meas(1'b1, 1'b0, n);
    chk(n >= T && n <= 2 * T + 3, 1'b1);
    neg_req = 1'b0;
    meas(1'b0, 1'b0, n);
    chk(n <= 2, 1'b1);
    wr(8'h14, 8'hff);
    rd(8'h13, d);
    chk(d, 8'h00);
    rd(8'h10, d);
    chk(d, 8'h00);
    chk(levels, 26'h0);
    chk(flag, 1'b1);
    print_verdict();
  end
endmodule // dbsc_regs_tb
`default_nettype wire
